// >>> core/adsa_pkg.sv
// Package of constants and state types for the alarm timing and setpoint access block
`default_nettype none
package adsa_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int FLASH_HALF_MS = 500;
  localparam int HALF_SEC_CYCLES = FLASH_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DEBOUNCE_MS = 20;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CHORD_MS = 150;
  localparam int CHORD_CYCLES = CHORD_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [3:0] INACTIVE_S = 4'ha;
  localparam logic [11:0] MAX_SECONDS = 12'he10;
  localparam int NUM_ALARMS = 2;
  localparam int CODE_DIGITS = 4;
  localparam int SP_DIGITS = 8;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [15:0] CODE_NONE = 16'h0000;

  typedef enum logic [3:0] {
    ALM_IDLE = 4'h1,
    ALM_DELAY = 4'h2,
    ALM_ACTIVE = 4'h4,
    ALM_SILENCED = 4'h8
  } adsa_alarm_e;

  typedef enum logic [4:0] {
    MNU_DISPLAY = 5'h01,
    MNU_CODE_PROMPT = 5'h02,
    MNU_CODE_ENTRY = 5'h04,
    MNU_SP_PROMPT = 5'h08,
    MNU_SP_EDIT = 5'h10
  } adsa_menu_e;
endpackage
`default_nettype wire

// >>> core/adsa_debounce.sv
// Push-button synchroniser and debouncer with a press pulse
`default_nettype none
module adsa_debounce #(
  parameter int DEB_CYCLES = adsa_pkg::DEBOUNCE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic button_pin,
  output logic level,
  output logic press
);
  logic s1_r, s2_r, s3_r;
  logic level_r;
  logic press_r;
  logic [31:0] cnt_r;
  wire agree = (s2_r == s3_r);
  wire differs = agree && (s3_r != level_r);
  wire settled = differs && (cnt_r >= 32'(DEB_CYCLES - 1));

  always_ff @(posedge sys_clk) begin
    s1_r <= button_pin;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // Counter restarts whenever the pin bounces back, so only a steady level is taken
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level_r <= 1'b0;
      press_r <= 1'b0;
      cnt_r <= 32'h0;
    end else begin
      press_r <= settled && s3_r;
      if (!differs) begin
        cnt_r <= 32'h0;
      end else if (settled) begin
        cnt_r <= 32'h0;
        level_r <= s3_r;
      end else begin
        cnt_r <= cnt_r + 32'h1;
      end
    end
  end

  assign level = level_r;
  assign press = press_r;
endmodule
`default_nettype wire

// >>> core/adsa_top.sv
// Alarm delay, silence, annunciator and direct setpoint access logic
// Notes on behaviour
// - Activation delay is 0 to 3600 s in 1 s steps; zero activates at once.
// - On alarm, annunciator flashes through the delay, then output goes active.
// - Nonzero silence time makes P in display mode an accept button.
// - Accept after an alarm returns output to non-alarm for the silence time.
// - Annunciator still shows an alarm after it is accepted and silenced.
// - Silence time is 0 to 3600 s in 1 s steps.
// - While silenced the annunciator flashes until the silence time runs out.
// - Digit entry: up/down change digit, P next digit, E commits and returns.
// - Direct access enable is on or off, toggled by up/down when edited.
// - With direct access off, setpoints cannot be reached from display mode.
// - A separate four-digit access code guards the direct setpoint menu.
// - Code 0000 means no protection; access granted without code check.
// - Direct menu entered only by P and Up together with access enabled.
// - Unprotected entry shows setpoint one prompt, marked rate or total.
// - Protected entry asks for code with flashing digit; correct code plus E.
// - At setpoint prompt, up or down toggles between setpoint one and two.
// - Wrong code or ten seconds without a button returns to display mode.
// - After setpoint edit, E returns to prompt; another E to display mode.
`default_nettype none
module adsa_top #(
  parameter int HALF_SEC_CYCLES = adsa_pkg::HALF_SEC_CYCLES,
  parameter int DEB_CYCLES = adsa_pkg::DEBOUNCE_CYCLES,
  parameter int CHORD_CYCLES = adsa_pkg::CHORD_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic btn_p_pin,
  input wire logic btn_up_pin,
  input wire logic btn_down_pin,
  input wire logic btn_e_pin,
  input wire logic [1:0] alarm_condition,
  input wire logic [1:0] alarm_type_total,
  input wire logic [11:0] activation_delay_setting_0,
  input wire logic [11:0] activation_delay_setting_1,
  input wire logic [11:0] silence_duration_setting_0,
  input wire logic [11:0] silence_duration_setting_1,
  input wire logic enable_edit,
  input wire logic code_load,
  input wire logic [15:0] code_load_value,
  output logic direct_access_enable,
  output logic [15:0] access_code,
  output logic [1:0] alarm_output_active,
  output logic [1:0] annunciator_lit,
  output logic p_normal_press,
  output logic [4:0] menu_state,
  output logic prompt_is_total,
  output logic setpoint_two_selected,
  output logic [2:0] digit_index,
  output logic digit_flash_on,
  output logic [15:0] code_entry,
  output logic [31:0] setpoint_one,
  output logic [31:0] setpoint_two
);
  // Next BCD digit up or down, wrapping 9 to 0
  function automatic logic [3:0] digit_step(input logic [3:0] d, input logic up);
    logic [3:0] r;
    r = 4'h0;
    if (up) begin
      r = (d >= adsa_pkg::DIGIT_MAX) ? 4'h0 : d + 4'h1;
    end else begin
      r = (d == 4'h0) ? adsa_pkg::DIGIT_MAX : d - 4'h1;
    end
    return r;
  endfunction

  logic p_lvl, up_lvl, p_prs, up_prs, dn_prs, e_prs;
  adsa_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_db_p (.sys_clk(sys_clk), .rst(rst),
    .button_pin(btn_p_pin), .level(p_lvl), .press(p_prs));
  adsa_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_db_up (.sys_clk(sys_clk), .rst(rst),
    .button_pin(btn_up_pin), .level(up_lvl), .press(up_prs));
  adsa_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_db_dn (.sys_clk(sys_clk), .rst(rst),
    .button_pin(btn_down_pin), .level(), .press(dn_prs));
  adsa_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_db_e (.sys_clk(sys_clk), .rst(rst),
    .button_pin(btn_e_pin), .level(), .press(e_prs));

  // Half-second divider; every second half-tick is the one-second tick
  logic [31:0] div_r;
  logic phase_r;
  wire half_tick = (div_r >= 32'(HALF_SEC_CYCLES - 1));
  wire sec_tick = half_tick && phase_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_r <= 32'h0;
      phase_r <= 1'b0;
    end else begin
      div_r <= half_tick ? 32'h0 : div_r + 32'h1;
      if (half_tick) begin
        phase_r <= ~phase_r;
      end
    end
  end
  wire flash = phase_r;

  // A lone P is held back for the window so a following Up turns it into the chord
  logic chord_pend_r;
  logic [31:0] chord_cnt_r;
  wire chord_exp = chord_pend_r && (chord_cnt_r >= 32'(CHORD_CYCLES - 1));
  // An Up landing within the window after P is read as a chord; one after the window while P is held is dropped
  wire ev_chord = (chord_pend_r && up_prs) || (p_prs && up_lvl);
  wire ev_p = chord_exp && !up_lvl;
  wire ev_up = up_prs && !chord_pend_r && !p_lvl;
  wire ev_any = ev_chord || ev_p || ev_up || dn_prs || e_prs;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chord_pend_r <= 1'b0;
      chord_cnt_r <= 32'h0;
    end else if (p_prs && !up_lvl) begin
      chord_pend_r <= 1'b1;
      chord_cnt_r <= 32'h0;
    end else if (ev_chord || chord_exp) begin
      chord_pend_r <= 1'b0;
      chord_cnt_r <= 32'h0;
    end else if (chord_pend_r) begin
      chord_cnt_r <= chord_cnt_r + 32'h1;
    end
  end

  adsa_pkg::adsa_menu_e menu_r, menu_nxt;
  wire in_display = (menu_r == adsa_pkg::MNU_DISPLAY);
  wire [11:0] sil_set [2];
  wire [11:0] dly_set [2];
  assign sil_set[0] = silence_duration_setting_0;
  assign sil_set[1] = silence_duration_setting_1;
  assign dly_set[0] = activation_delay_setting_0;
  assign dly_set[1] = activation_delay_setting_1;
  wire accept_mode = (sil_set[0] != 12'h0) || (sil_set[1] != 12'h0);
  wire accept_ev = ev_p && in_display && accept_mode;
  logic p_norm_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p_norm_r <= 1'b0;
    end else begin
      p_norm_r <= ev_p && in_display && !accept_mode;
    end
  end
  assign p_normal_press = p_norm_r;

  // Per-alarm delay and silence sequencing
  adsa_pkg::adsa_alarm_e alm_r [2];
  logic [11:0] alm_cnt_r [2];
  logic [1:0] out_r, ann_r;
  genvar g;
  generate
    for (g = 0; g < adsa_pkg::NUM_ALARMS; g++) begin : g_alarm
      wire [11:0] dly = (dly_set[g] > adsa_pkg::MAX_SECONDS) ? adsa_pkg::MAX_SECONDS
        : dly_set[g];
      wire [11:0] silence_duration_setting = (sil_set[g] > adsa_pkg::MAX_SECONDS) ? adsa_pkg::MAX_SECONDS
        : sil_set[g];
      wire cnt_done = sec_tick && (alm_cnt_r[g] <= 12'h1);
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          alm_r[g] <= adsa_pkg::ALM_IDLE;
          alm_cnt_r[g] <= 12'h0;
        end else if (!alarm_condition[g]) begin
          alm_r[g] <= adsa_pkg::ALM_IDLE;
          alm_cnt_r[g] <= 12'h0;
        end else begin
          case (alm_r[g])
            adsa_pkg::ALM_IDLE: begin
              alm_cnt_r[g] <= dly;
              alm_r[g] <= (dly == 12'h0) ? adsa_pkg::ALM_ACTIVE
                : adsa_pkg::ALM_DELAY;
            end
            adsa_pkg::ALM_DELAY: begin
              if (cnt_done) begin
                alm_r[g] <= adsa_pkg::ALM_ACTIVE;
              end else if (sec_tick) begin
                alm_cnt_r[g] <= alm_cnt_r[g] - 12'h1;
              end
            end
            adsa_pkg::ALM_ACTIVE: begin
              if (accept_ev && silence_duration_setting != 12'h0) begin
                alm_r[g] <= adsa_pkg::ALM_SILENCED;
                alm_cnt_r[g] <= silence_duration_setting;
              end
            end
            adsa_pkg::ALM_SILENCED: begin
              if (cnt_done) begin
                alm_r[g] <= adsa_pkg::ALM_ACTIVE;
              end else if (sec_tick) begin
                alm_cnt_r[g] <= alm_cnt_r[g] - 12'h1;
              end
            end
            default: begin
              alm_r[g] <= adsa_pkg::ALM_IDLE;
            end
          endcase
        end
      end
      wire ann_nxt = (alm_r[g] == adsa_pkg::ALM_ACTIVE) ? 1'b1
        : (alm_r[g] == adsa_pkg::ALM_DELAY || alm_r[g] == adsa_pkg::ALM_SILENCED)
        ? flash : 1'b0;
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          out_r[g] <= 1'b0;
          ann_r[g] <= 1'b0;
        end else begin
          out_r[g] <= (alm_r[g] == adsa_pkg::ALM_ACTIVE);
          ann_r[g] <= ann_nxt;
        end
      end
    end
  endgenerate
  assign alarm_output_active = out_r;
  assign annunciator_lit = ann_r;

  // Direct access settings, edited from the programme menu outside
  logic enable_r;
  logic [15:0] code_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enable_r <= 1'b0;
      code_r <= adsa_pkg::CODE_NONE;
    end else begin
      if (enable_edit && (up_prs || dn_prs)) begin
        enable_r <= ~enable_r;
      end
      if (code_load) begin
        code_r <= code_load_value;
      end
    end
  end
  assign direct_access_enable = enable_r;
  assign access_code = code_r;

  // Direct setpoint menu
  logic [15:0] entry_r;
  logic [2:0] idx_r;
  logic sel_r;
  logic [3:0] idle_r;
  logic [31:0] sp_r [2];
  wire code_ok = (entry_r == code_r);
  wire idle_out = sec_tick && (idle_r >= adsa_pkg::INACTIVE_S - 4'h1);
  wire step_ev = ev_up || dn_prs;
  wire [3:0] code_dig = entry_r[4*idx_r[1:0] +: 4];
  wire [3:0] sp_dig = sp_r[sel_r][4*idx_r +: 4];

  always_comb begin
    menu_nxt = menu_r;
    case (menu_r)
      adsa_pkg::MNU_DISPLAY: begin
        if (ev_chord && enable_r) begin
          menu_nxt = (code_r == adsa_pkg::CODE_NONE) ? adsa_pkg::MNU_SP_PROMPT
            : adsa_pkg::MNU_CODE_PROMPT;
        end
      end
      adsa_pkg::MNU_CODE_PROMPT: begin
        if (ev_p) begin
          menu_nxt = adsa_pkg::MNU_CODE_ENTRY;
        end else if (e_prs) begin
          menu_nxt = adsa_pkg::MNU_DISPLAY;
        end
      end
      adsa_pkg::MNU_CODE_ENTRY: begin
        if (e_prs) begin
          menu_nxt = code_ok ? adsa_pkg::MNU_SP_PROMPT : adsa_pkg::MNU_DISPLAY;
        end
      end
      adsa_pkg::MNU_SP_PROMPT: begin
        if (ev_p) begin
          menu_nxt = adsa_pkg::MNU_SP_EDIT;
        end else if (e_prs) begin
          menu_nxt = adsa_pkg::MNU_DISPLAY;
        end
      end
      adsa_pkg::MNU_SP_EDIT: begin
        if (e_prs) begin
          menu_nxt = adsa_pkg::MNU_SP_PROMPT;
        end
      end
      default: begin
        menu_nxt = adsa_pkg::MNU_DISPLAY;
      end
    endcase
    if (!in_display && idle_out) begin
      menu_nxt = adsa_pkg::MNU_DISPLAY;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      menu_r <= adsa_pkg::MNU_DISPLAY;
    end else begin
      menu_r <= menu_nxt;
    end
  end

  // Idle seconds restart on every button event while in the menu
  always_ff @(posedge sys_clk) begin
    if (rst || in_display || ev_any) begin
      idle_r <= 4'h0;
    end else if (sec_tick) begin
      idle_r <= idle_r + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      entry_r <= adsa_pkg::CODE_NONE;
      idx_r <= 3'h0;
      sel_r <= 1'b0;
    end else begin
      if (menu_nxt != menu_r) begin
        idx_r <= 3'h0;
      end
      if (menu_r == adsa_pkg::MNU_DISPLAY) begin
        entry_r <= adsa_pkg::CODE_NONE;
        sel_r <= 1'b0;
      end
      if (menu_r == adsa_pkg::MNU_CODE_ENTRY) begin
        if (step_ev) begin
          entry_r[4*idx_r[1:0] +: 4] <= digit_step(code_dig, ev_up);
        end else if (ev_p) begin
          idx_r <= {1'b0, idx_r[1:0] + 2'h1};
        end
      end
      if (menu_r == adsa_pkg::MNU_SP_PROMPT && step_ev) begin
        sel_r <= ~sel_r;
      end
      if (menu_r == adsa_pkg::MNU_SP_EDIT && ev_p) begin
        idx_r <= idx_r + 3'h1;
      end
    end
  end

  // Setpoints are edited in place; the comparator outside reads them directly
  generate
    for (g = 0; g < adsa_pkg::NUM_ALARMS; g++) begin : g_sp
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          sp_r[g] <= 32'h0;
        end else if (menu_r == adsa_pkg::MNU_SP_EDIT && step_ev && sel_r == 1'(g)) begin
          sp_r[g][4*idx_r +: 4] <= digit_step(sp_dig, ev_up);
        end
      end
    end
  endgenerate

  logic flash_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flash_r <= 1'b0;
    end else begin
      flash_r <= (menu_r == adsa_pkg::MNU_CODE_ENTRY || menu_r == adsa_pkg::MNU_SP_EDIT)
        && flash;
    end
  end

  assign menu_state = menu_r;
  assign prompt_is_total = alarm_type_total[sel_r];
  assign setpoint_two_selected = sel_r;
  assign digit_index = idx_r;
  assign digit_flash_on = flash_r;
  assign code_entry = entry_r;
  assign setpoint_one = sp_r[0];
  assign setpoint_two = sp_r[1];
endmodule
`default_nettype wire

// >>> sim/adsa_chk.sv
// Concurrent checks on the alarm timing and direct menu ports
`default_nettype none
module adsa_chk #(
  parameter int HALF_SEC_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic btn_p_pin,
  input wire logic btn_up_pin,
  input wire logic btn_down_pin,
  input wire logic btn_e_pin,
  input wire logic [1:0] alarm_condition,
  input wire logic [1:0] alarm_type_total,
  input wire logic [11:0] activation_delay_setting_0,
  input wire logic [11:0] activation_delay_setting_1,
  input wire logic [11:0] silence_duration_setting_0,
  input wire logic [11:0] silence_duration_setting_1,
  input wire logic direct_access_enable,
  input wire logic [15:0] access_code,
  input wire logic [1:0] alarm_output_active,
  input wire logic p_normal_press,
  input wire logic [4:0] menu_state,
  input wire logic prompt_is_total,
  input wire logic setpoint_two_selected,
  input wire logic [15:0] code_entry
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Counted from the last release, so ten ticks plus a partial one always fit
  localparam int IDLE_MAX = 21 * HALF_SEC_CYCLES;
  int idle_r;
  wire any_btn = btn_p_pin | btn_up_pin | btn_down_pin | btn_e_pin;
  always_ff @(posedge sys_clk) begin
    if (rst || any_btn || menu_state == 5'h01) idle_r <= 0;
    else idle_r <= idle_r + 1;
  end
  sequence s_menu_entry;
    $past(menu_state) == 5'h01 && menu_state != 5'h01;
  endsequence
  sequence s_delay_start;
    $rose(alarm_condition[0]) && activation_delay_setting_0 > 12'h001;
  endsequence
  a_off_no_entry: assert property (menu_state == 5'h01 && !direct_access_enable |=>
    menu_state == 5'h01) else $error("menu entered with access off");
  a_entry_gate: assert property (s_menu_entry |-> direct_access_enable &&
    menu_state == ((access_code == 16'h0000) ? 5'h08 : 5'h02)) else $error("bad entry");
  a_prompt_mark: assert property (menu_state == 5'h08 && $past(menu_state) != 5'h08 &&
    $past(menu_state) != 5'h10 |-> !setpoint_two_selected &&
    prompt_is_total == alarm_type_total[0]) else $error("bad mark");
  a_code_match: assert property (menu_state == 5'h08 && $past(menu_state) == 5'h04 |->
    $past(code_entry) == access_code) else $error("prompt without code");
  a_zero_delay: assert property ($rose(alarm_condition[1]) &&
    activation_delay_setting_1 == 12'h000 ##1 alarm_condition[1] |=> alarm_output_active[1])
    else $error("zero delay output late");
  a_delay_wait: assert property (s_delay_start |=> !alarm_output_active[0] [*8])
    else $error("output before delay");
  a_accept_only: assert property ($fell(alarm_output_active[0]) &&
    $past(alarm_condition[0], 2) && $past(alarm_condition[0]) |->
    silence_duration_setting_0 != 12'h000) else $error("output dropped without silence");
  a_p_normal: assert property (p_normal_press |-> silence_duration_setting_0 == 12'h000 &&
    silence_duration_setting_1 == 12'h000 && $past(menu_state) == 5'h01)
    else $error("normal press with silence set");
  a_idle_exit: assert property (idle_r < IDLE_MAX)
    else $error("menu kept past inactivity");
endmodule
bind adsa_top adsa_chk #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) u_chk (.sys_clk, .rst, .btn_p_pin,
  .btn_up_pin, .btn_down_pin, .btn_e_pin, .alarm_condition, .alarm_type_total,
  .activation_delay_setting_0, .activation_delay_setting_1, .silence_duration_setting_0,
  .silence_duration_setting_1, .direct_access_enable, .access_code, .alarm_output_active,
  .p_normal_press, .menu_state, .prompt_is_total, .setpoint_two_selected, .code_entry);
`default_nettype wire

// >>> sim/adsa_btn_model.sv
// Operator push-button model with contact bounce
`default_nettype none
module adsa_btn_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [3:0] mask,
  output logic busy,
  output logic [3:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  logic [3:0] held = 4'h0;
  always @(posedge sys_clk) begin
    if (rst) cnt <= 0;
    else if (go) begin
      cnt <= 56;
      held <= mask;
    end else if (cnt > 0) cnt <= cnt - 1;
  end
  // One open cycle early in the press mimics chatter; released pins read low
  assign pins = (cnt > 28 && cnt != 54) ? held : 4'h0;
  assign busy = cnt > 0;
endmodule
`default_nettype wire

// >>> sim/adsa_top_tb.sv
// Bench for the alarm timing and direct setpoint menu block
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module adsa_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] PB = 4'h8, UB = 4'h4, DB = 4'h2, EB = 4'h1, CB = 4'hc;
  logic sys_clk = 1'b0, rst = 1'b1, go = 1'b0, enable_edit = 1'b0, code_load = 1'b0;
  logic [3:0] mask = 4'h0;
  logic [1:0] cond = 2'b00;
  logic [1:0] atype = 2'b10;
  logic [11:0] dly0 = 12'h000, sil0 = 12'h000;
  logic [15:0] code_v = 16'h0000;
  logic [3:0] seq[$] = '{CB, DB, PB, UB, PB, DB, EB, UB, EB};
  wire busy, en, pnp, sel, fl, prm;
  wire [3:0] pins;
  wire [1:0] out, lit;
  wire [4:0] mst;
  wire [2:0] idx;
  wire [15:0] acode, cent;
  wire [31:0] sp1, sp2;
  int n_errors = 0, checks_done = 0, seed = 1, n_pp = 0, hi, lo;
  int m_menu = 1, m_sel = 0, m_idx = 0, m_en = 0, m_code = 0, m_ent = 0, m_sp[2] = '{0, 0};
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (pnp === 1'b1) n_pp++;
  adsa_btn_model u_btn (.sys_clk, .rst, .go, .mask, .busy, .pins);
  adsa_top #(.HALF_SEC_CYCLES(20), .DEB_CYCLES(4), .CHORD_CYCLES(8)) dut (.sys_clk, .rst,
    .btn_p_pin(pins[3]), .btn_up_pin(pins[2]), .btn_down_pin(pins[1]), .btn_e_pin(pins[0]),
    .alarm_condition(cond), .alarm_type_total(atype), .activation_delay_setting_0(dly0),
    .activation_delay_setting_1(12'h000), .silence_duration_setting_0(sil0),
    .silence_duration_setting_1(12'h000), .enable_edit, .code_load,
    .code_load_value(code_v), .direct_access_enable(en), .access_code(acode),
    .alarm_output_active(out), .annunciator_lit(lit), .p_normal_press(pnp), .menu_state(mst),
    .prompt_is_total(prm), .setpoint_two_selected(sel), .digit_index(idx),
    .digit_flash_on(fl), .code_entry(cent), .setpoint_one(sp1), .setpoint_two(sp2));
  task automatic complete_run();
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Waits on busy (0), display mode (1) or alarm one output (2)
  task automatic await(input int w, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge sys_clk);
      #1;
      if (w == 0 ? busy === 1'b0 : (w == 1 ? mst === 5'h01 : out[0] === 1'b1)) break;
    end
    if (i == lim) begin
      n_errors++;
      $display("mismatch wait %0d exp done got timeout", w);
      complete_run();
    end
  endtask
  task automatic sample(input int n, input int w);
    hi = 0;
    lo = 0;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      if ((w ? lit[0] : fl) === 1'b1) hi++;
      else lo++;
    end
  endtask
  function automatic int bump(int v, int k, int dl);
    int n;
    n = ((v >> (4 * k)) & 15) + dl;
    n = n > 9 ? 0 : (n < 0 ? 9 : n);
    return (v & ~(15 << (4 * k))) | (n << (4 * k));
  endfunction
  task automatic act(input logic [3:0] m);
    int v;
    @(posedge sys_clk);
    go <= 1'b1;
    mask <= m;
    @(posedge sys_clk);
    go <= 1'b0;
    await(0, 200);
    v = m_menu;
    case (m_menu)
      1: begin
        if (m == CB && m_en == 1) m_menu = m_code == 0 ? 8 : 2;
        if (m == UB && enable_edit === 1'b1) m_en ^= 1;
        m_sel = 0;
      end
      2: m_menu = m == PB ? 4 : (m == EB ? 1 : 2);
      4: begin
        if (m == UB) m_ent = bump(m_ent, m_idx, 1);
        if (m == EB) m_menu = m_ent == m_code ? 8 : 1;
      end
      8: begin
        if (m == UB || m == DB) m_sel ^= 1;
        m_menu = m == PB ? 16 : (m == EB ? 1 : 8);
      end
      default: begin
        if (m == UB || m == DB) m_sp[m_sel] = bump(m_sp[m_sel], m_idx, m == UB ? 1 : -1);
        if (m == EB) m_menu = 8;
      end
    endcase
    if (m == PB) m_idx = v != m_menu ? 0 : (m_idx + 1) % 8;
    if (v != m_menu) m_ent = 0;
    `CHK("menu", 5'(m_menu), mst)
    `CHK("sel", 1'(m_sel), sel)
    `CHK("enable", 1'(m_en), en)
    `CHK("sp1", 32'(m_sp[0]), sp1)
    `CHK("sp2", 32'(m_sp[1]), sp2)
    if (m_menu == 16) `CHK("digit", 3'(m_idx), idx)
    if (m_menu == 4) `CHK("entry", 16'(m_ent), cent)
    if (m_menu == 8) `CHK("mark", atype[m_sel], prm)
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    atype <= 2'($random(seed));
    #1;
    `CHK("code", 16'h0000, acode)
    `CHK("outputs", 2'b00, out)
    act(PB);
    `CHK("normal", 1, n_pp)
    act(CB);
    @(posedge sys_clk) enable_edit <= 1'b1;
    act(UB);
    @(posedge sys_clk) enable_edit <= 1'b0;
    foreach (seq[k]) act(seq[k]);
    act(CB);
    repeat (300) @(posedge sys_clk);
    #1;
    `CHK("menu", 5'h08, mst)
    await(1, 200);
    m_menu = 1;
    for (int k = 0; k < 4; k++) m_code |= ((($random(seed) & 7) + 1) << (4 * k));
    @(posedge sys_clk) code_v <= 16'(m_code);
    code_load <= 1'b1;
    @(posedge sys_clk) code_load <= 1'b0;
    #1;
    `CHK("code", 16'(m_code), acode)
    act(CB);
    act(EB);
    act(CB);
    act(PB);
    act(EB);
    act(CB);
    act(PB);
    sample(50, 0);
    `CHK("flash", 1'b1, 1'(hi > 0 && lo > 0))
    for (int k = 0; k < 4; k++) begin
      repeat ((m_code >> (4 * k)) & 15) act(UB);
      if (k < 3) act(PB);
    end
    act(EB);
    act(EB);
    @(posedge sys_clk) dly0 <= 12'(2 + ($random(seed) & 1));
    cond <= 2'b11;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("out1", 1'b1, out[1])
    `CHK("lit1", 1'b1, lit[1])
    sample(30, 1);
    `CHK("flash", 1'b1, 1'(hi > 0 && lo > 0))
    `CHK("out0", 1'b0, out[0])
    await(2, 150);
    @(posedge sys_clk) sil0 <= 12'h003;
    act(PB);
    `CHK("out0", 1'b0, out[0])
    `CHK("out1", 1'b1, out[1])
    `CHK("normal", 1, n_pp)
    sample(30, 1);
    `CHK("flash", 1'b1, 1'(hi > 0 && lo > 0))
    `CHK("lit", 1'b1, 1'(hi > 0))
    await(2, 150);
    `CHK("lit", 1'b1, lit[0])
    @(posedge sys_clk) cond <= 2'b00;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("outputs", 2'b00, out)
    complete_run();
  end
endmodule
`default_nettype wire
